// file: hdl/aoc_dev.sv
// converter end: strap decode, output pipeline, coding, flag and drive control
`timescale 1ns/100ps
module aoc_dev (
   input  wire logic        clk_i,          // sample clock
   input  wire logic        rst_n_i,        // async reset, active low
   input  wire logic [11:0] sample_i,       // raw offset binary code from the core
   input  wire logic        over_i,         // core saw input beyond range
   output logic             span_two_o,     // span factor 2 selected
   output logic             scaling_on_o,   // power scaling enabled
   output logic             core_run_o,     // reference, bias, clock running
   output logic             stab_on_o,      // duty stabilizer enabled
   output logic             ready_o,        // wake and relock intervals elapsed
   aoc_if.dev               bus             // pin side
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [11:0] aoc_to_gray(input logic [11:0] b);
      aoc_to_gray = b ^ {1'b0, b[11:1]};
   endfunction

   // both middle levels switch the same feature on for two different pins
   function automatic logic aoc_mid_level(input aoc_pkg::aoc_level_t l);
      aoc_mid_level = (l == aoc_pkg::AOC_LVL_TWO3) || (l == aoc_pkg::AOC_LVL_THIRD);
   endfunction

   aoc_pkg::aoc_level_t rng_l, pwr_l, fmt_l;
   aoc_pkg::aoc_pwr_t   pwr_mode;
   logic                twos_sel;

   // missing strap sources arrive as ground, matching the internal pull-downs
   always_comb begin
      rng_l = aoc_pkg::aoc_level_t'(bus.range_power_select);
      pwr_l = aoc_pkg::aoc_level_t'(bus.power_state_select);
      fmt_l = aoc_pkg::aoc_level_t'(bus.format_select);
      span_two_o   = (rng_l == aoc_pkg::AOC_LVL_GND) || (rng_l == aoc_pkg::AOC_LVL_THIRD);
      scaling_on_o = aoc_mid_level(rng_l);
      case (pwr_l)
         aoc_pkg::AOC_LVL_TOP:   pwr_mode = aoc_pkg::AOC_PWR_DOWN;
         aoc_pkg::AOC_LVL_THIRD: pwr_mode = aoc_pkg::AOC_PWR_STANDBY;
         default:                pwr_mode = aoc_pkg::AOC_PWR_NORMAL;
      endcase
      twos_sel  = (fmt_l == aoc_pkg::AOC_LVL_TOP) || (fmt_l == aoc_pkg::AOC_LVL_TWO3);
      stab_on_o = aoc_mid_level(fmt_l) && (pwr_mode != aoc_pkg::AOC_PWR_DOWN);
      core_run_o = (pwr_mode != aoc_pkg::AOC_PWR_DOWN);
   end

   ////////////////////////////////////////////////////////////////////////////
   // coding applied at the pipe input so every stage holds the final word
   logic [11:0] coded;
   always_comb begin
      if (bus.gray_select)
         coded = aoc_to_gray(sample_i);
      else if (twos_sel)
         coded = sample_i ^ aoc_pkg::MSB_MASK;
      else
         coded = sample_i;
   end

   logic [11:0] pipe_q [aoc_pkg::PIPE_DEPTH];
   logic [11:0] pipe_d [aoc_pkg::PIPE_DEPTH];
   logic [aoc_pkg::PIPE_DEPTH-1:0] flag_q, flag_d;
   always_comb begin
      pipe_d[0] = coded;
      flag_d[0] = over_i;
      for (int i = 1; i < aoc_pkg::PIPE_DEPTH; i++) begin
         pipe_d[i] = pipe_q[i-1];
         flag_d[i] = flag_q[i-1];
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < aoc_pkg::PIPE_DEPTH; i++)
            pipe_q[i] <= aoc_pkg::DATA_RST;
         flag_q <= '0;
      end else begin
         pipe_q <= pipe_d;
         flag_q <= flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power sequencing: full 3 ms wake after power-down; relock after a rate
   // change or the stabilizer being turned on. the worst case is always
   // waited, trading speed for never presenting a word too early.
   typedef enum logic [1:0] {
      AOC_ST_RUN  = 2'h0,                   // converting, words trusted
      AOC_ST_DOWN = 2'h1,                   // core stopped, counter held full
      AOC_ST_WAKE = 2'h2,                   // reference recharging
      AOC_ST_LOCK = 2'h3                    // stabilizer reacquiring the clock
   } aoc_seq_t;

   aoc_seq_t    seq_q, seq_d;
   logic [16:0] wait_q, wait_d;
   logic        stab_was_q;
   logic        down_req;
   logic        relock_req;

   assign down_req   = (pwr_mode == aoc_pkg::AOC_PWR_DOWN);
   assign relock_req = bus.rate_change || (stab_on_o && !stab_was_q);

   always_comb begin
      seq_d  = seq_q;
      wait_d = wait_q;
      case (seq_q)
         AOC_ST_RUN: begin
            if (down_req) begin
               seq_d  = AOC_ST_DOWN;
               wait_d = 17'(aoc_pkg::WAKE_CYC);
            end else if (relock_req) begin
               seq_d  = AOC_ST_LOCK;
               wait_d = 17'(aoc_pkg::RELOCK_CYC);
            end
         end

         AOC_ST_DOWN: begin
            // the exit edge already counts, keeping step with the receiver
            if (down_req) begin
               wait_d = 17'(aoc_pkg::WAKE_CYC);
            end else begin
               seq_d  = AOC_ST_WAKE;
               wait_d = wait_q - 17'h00001;
            end
         end

         AOC_ST_WAKE: begin
            if (down_req) begin
               seq_d  = AOC_ST_DOWN;
               wait_d = 17'(aoc_pkg::WAKE_CYC);
            end else if (relock_req && (wait_q < 17'(aoc_pkg::RELOCK_CYC))) begin
               wait_d = 17'(aoc_pkg::RELOCK_CYC);
            end else if (wait_q == 17'h00000) begin
               seq_d  = AOC_ST_RUN;
            end else begin
               wait_d = wait_q - 17'h00001;
            end
         end

         // a rate that keeps moving holds the counter full until it stops
         AOC_ST_LOCK: begin
            if (down_req) begin
               seq_d  = AOC_ST_DOWN;
               wait_d = 17'(aoc_pkg::WAKE_CYC);
            end else if (relock_req) begin
               wait_d = 17'(aoc_pkg::RELOCK_CYC);
            end else if (wait_q == 17'h00000) begin
               seq_d  = AOC_ST_RUN;
            end else begin
               wait_d = wait_q - 17'h00001;
            end
         end

         // an unknown code restarts the full wake rather than risk early words
         default: begin
            seq_d  = AOC_ST_WAKE;
            wait_d = 17'(aoc_pkg::WAKE_CYC);
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_q      <= AOC_ST_WAKE;
         wait_q     <= 17'(aoc_pkg::WAKE_CYC);
         stab_was_q <= 1'b0;
      end else begin
         seq_q      <= seq_d;
         wait_q     <= wait_d;
         stab_was_q <= stab_on_o;
      end
   end
   assign ready_o = (seq_q == AOC_ST_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // standby and power-down float the pins but leave the pipe running; it keeps flowing so
   // the first driven word after a release is already a current sample
   logic drive;
   assign drive = !bus.output_release && (pwr_mode == aoc_pkg::AOC_PWR_NORMAL);
   assign bus.data_o              = pipe_q[aoc_pkg::PIPE_DEPTH-1];
   assign bus.range_exceeded_flag = flag_q[aoc_pkg::PIPE_DEPTH-1];
   for (genvar g = 0; g < aoc_pkg::DATA_W; g++) begin : g_oe
      assign bus.data_oe_n[g] = !drive;
   end
   assign bus.flag_oe_n           = !drive;
endmodule // aoc_dev

// file: hdl/aoc_rcv.sv
// receiver end: drives strap lines, latches words, classifies range
`timescale 1ns/100ps
module aoc_rcv (
   input  wire logic        clk_i,          // sample clock
   input  wire logic        rst_n_i,        // async reset, active low
   input  wire logic [1:0]  range_sel_i,    // requested range/power level
   input  wire logic [1:0]  power_sel_i,    // requested power state level
   input  wire logic [1:0]  format_sel_i,   // requested format level
   input  wire logic        gray_i,         // request gray coding
   input  wire logic        release_i,      // request bus release
   input  wire logic        rate_change_i,  // sample clock rate is changing
   output logic [11:0]      word_o,         // latched sample word
   output logic             word_valid_o,   // word_o trusted this cycle
   output logic             under_o,        // latched binary or gray sample below range
   output logic             over_o,         // latched binary or gray sample above range
   aoc_if.rcv               bus             // pin side
);
   logic [16:0] hold_q, hold_d;
   logic [11:0] word_d;
   logic        valid_d, under_d, over_d;
   logic        rate_dirty_q;

   // scaling is dropped while the rate moves and until it has settled
   assign bus.range_power_select = ((rate_change_i || rate_dirty_q) &&
         (range_sel_i == 2'h1 || range_sel_i == 2'h2)) ? 2'h0 : range_sel_i;
   assign bus.power_state_select = power_sel_i;
   assign bus.format_select      = format_sel_i;
   assign bus.gray_select        = gray_i;
   assign bus.output_release     = release_i;
   assign bus.rate_change        = rate_change_i;

   always_comb begin
      hold_d = (hold_q != 17'h00000) ? hold_q - 17'h00001 : hold_q;
      if (power_sel_i == 2'h3)
         hold_d = 17'(aoc_pkg::WAKE_CYC);
      else if (rate_change_i && hold_q < 17'(aoc_pkg::RELOCK_CYC))
         hold_d = 17'(aoc_pkg::RELOCK_CYC);
      valid_d = (hold_q == 17'h00000) && !bus.data_oe_n[0];
      word_d  = bus.data_o;
      under_d = bus.range_exceeded_flag && !bus.data_o[11];
      over_d  = bus.range_exceeded_flag &&  bus.data_o[11];
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_q       <= 17'(aoc_pkg::WAKE_CYC);
         word_o       <= aoc_pkg::DATA_RST;
         word_valid_o <= 1'b0;
         under_o      <= 1'b0;
         over_o       <= 1'b0;
         rate_dirty_q <= 1'b0;
      end else begin
         hold_q       <= hold_d;
         word_o       <= word_d;
         word_valid_o <= valid_d;
         under_o      <= under_d && valid_d;
         over_o       <= over_d && valid_d;
         rate_dirty_q <= rate_change_i || (rate_dirty_q && hold_q != 17'h00000);
      end
   end
endmodule // aoc_rcv

// file: include/aoc_if.sv
// interface: parallel sample bus and strap lines between converter and receiver
`timescale 1ns/100ps
interface aoc_if;
   logic [11:0] data_o;      // sample word, valid when data_oe_n low
   logic [11:0] data_oe_n;   // per-bit output enable, low drives
   logic        range_exceeded_flag;
   logic        flag_oe_n;
   logic [1:0]  range_power_select;
   logic [1:0]  power_state_select;
   logic [1:0]  format_select;
   logic        gray_select;
   logic        output_release;
   logic        rate_change;  // receiver signals it changed the sample clock rate

   modport dev (output data_o, data_oe_n, range_exceeded_flag, flag_oe_n,
                input range_power_select, power_state_select, format_select,
                gray_select, output_release, rate_change);
   modport rcv (input data_o, data_oe_n, range_exceeded_flag, flag_oe_n,
                output range_power_select, power_state_select, format_select,
                gray_select, output_release, rate_change);
endinterface : aoc_if

// file: include/aoc_pkg.sv
// package: constants and types shared by the converter output control ends
package aoc_pkg;
   // multilevel pin inputs are carried as a 2-bit quantised level
   typedef enum logic [1:0] {
      AOC_LVL_GND   = 2'h0,                 // ground, the pulled-down default
      AOC_LVL_THIRD = 2'h1,                 // one third of the rail
      AOC_LVL_TWO3  = 2'h2,                 // two thirds of the rail
      AOC_LVL_TOP   = 2'h3                  // top rail
   } aoc_level_t;

   typedef enum logic [1:0] {
      AOC_PWR_NORMAL  = 2'h0,
      AOC_PWR_STANDBY = 2'h1,
      AOC_PWR_DOWN    = 2'h2
   } aoc_pwr_t;

   localparam int unsigned DATA_W       = 12;
   localparam int unsigned PIPE_DEPTH   = 8;       // sample clocks from sample to output
   localparam int unsigned CLK_HZ       = 20000000;
   localparam int unsigned WAKE_US      = 3000;    // 3 ms restore after power-down
   localparam int unsigned WAKE_CYC     = (WAKE_US * (CLK_HZ / 1000000));
   localparam int unsigned RELOCK_CYC   = 100;     // stabilizer relock after rate change
   localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
   localparam logic [DATA_W-1:0] MSB_MASK = 12'h800;
endpackage : aoc_pkg

// file: tb/adc_output_and_mode_control_tb.sv
// testbench: both ends joined at the pins, driven from the user sides
`timescale 1ns/100ps
module adc_output_and_mode_control_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [11:0] smp = 12'h000;
   logic        ovr_in = 1'b0;
   logic [1:0]  rsel = 2'h0, psel = 2'h0, fsel = 2'h0;
   logic        gray = 1'b0, rel = 1'b0, rchg = 1'b0;
   logic        span, scal, run, stab, rdy, wval, under, ovr;
   logic [11:0] word;
   int          error_cnt = 0, samples_checked = 0;
   aoc_if aoc_if_i ();
   always #25 clk_i = ~clk_i;
   aoc_dev aoc_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_i(smp), .over_i(ovr_in),
      .span_two_o(span), .scaling_on_o(scal), .core_run_o(run), .stab_on_o(stab),
      .ready_o(rdy), .bus(aoc_if_i.dev));
   aoc_rcv aoc_rcv_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .range_sel_i(rsel), .power_sel_i(psel),
      .format_sel_i(fsel), .gray_i(gray), .release_i(rel), .rate_change_i(rchg), .word_o(word),
      .word_valid_o(wval), .under_o(under), .over_o(ovr), .bus(aoc_if_i.rcv));
   aoc_asserts aoc_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_i(smp),
      .over_i(ovr_in), .ready_o(rdy), .data_o(aoc_if_i.data_o), .data_oe_n(aoc_if_i.data_oe_n),
      .range_exceeded_flag(aoc_if_i.range_exceeded_flag),
      .power_state_select(aoc_if_i.power_state_select), .format_select(aoc_if_i.format_select),
      .gray_select(aoc_if_i.gray_select), .output_release(aoc_if_i.output_release));
   task automatic chk_word(string n, logic [11:0] e, logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(string n, logic e, logic g);
      chk_word(n, {11'h000, e}, {11'h000, g});
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // word lands seven edges after the edge that takes it
   task automatic conv(logic [11:0] s, logic o);
      @(posedge clk_i);
      smp <= s;
      ovr_in <= o;
      tick(8);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int l = 0; l < 4; l++) begin
         @(posedge clk_i);
         rsel <= l[1:0];
         tick(3);
         chk_bit("span_two", l < 2, span);
         chk_bit("scaling", l == 1 || l == 2, scal);
      end
      $display("range test done");
      for (int l = 0; l < 4; l++) begin
         @(posedge clk_i);
         fsel <= l[1:0];
         conv(12'h5A3, 1'b0);
         chk_word("data", (l > 1) ? 12'hDA3 : 12'h5A3, aoc_if_i.data_o);
         chk_bit("stab", l == 1 || l == 2, stab);
      end
      @(posedge clk_i);
      gray <= 1'b1;
      fsel <= 2'h3;
      conv(12'hB6D, 1'b0);
      chk_word("gray", 12'hEDB, aoc_if_i.data_o);
      chk_bit("stab", 1'b0, stab);
      gray <= 1'b0;
      fsel <= 2'h1;
      conv(12'hFFF, 1'b1);
      chk_bit("flag", 1'b1, aoc_if_i.range_exceeded_flag);
      conv(12'h800, 1'b0);
      chk_bit("flag", 1'b0, aoc_if_i.range_exceeded_flag);
      $display("format test done");
      @(posedge clk_i);
      rel <= 1'b1;
      tick(3);
      chk_word("oe_n", 12'hFFF, aoc_if_i.data_oe_n);
      psel <= 2'h1;
      rel <= 1'b0;
      tick(3);
      chk_word("oe_n", 12'hFFF, aoc_if_i.data_oe_n);
      chk_bit("core_run", 1'b1, run);
      psel <= 2'h3;
      tick(3);
      chk_word("oe_n", 12'hFFF, aoc_if_i.data_oe_n);
      chk_bit("core_run", 1'b0, run);
      chk_bit("stab", 1'b0, stab);
      psel <= 2'h0;
      tick(3);
      chk_word("oe_n", 12'h000, aoc_if_i.data_oe_n);
      chk_bit("word_valid", 1'b0, wval);
      $display("drive test done");
      for (int i = 0; i < 70000 && wval !== 1'b1; i++) tick(1);
      chk_bit("word_valid", 1'b1, wval);
      chk_bit("ready", 1'b1, rdy);
      if (wval !== 1'b1) results();
      conv(12'hC00, 1'b1);
      tick(1);
      chk_word("word", 12'hC00, word);
      chk_bit("over", 1'b1, ovr);
      conv(12'h100, 1'b1);
      tick(1);
      chk_bit("under", 1'b1, under);
      $display("receive test done");
      rsel <= 2'h1;
      rchg <= 1'b1;
      tick(3);
      chk_bit("scaling", 1'b0, scal);
      chk_bit("ready", 1'b0, rdy);
      chk_bit("word_valid", 1'b0, wval);
      rchg <= 1'b0;
      tick(3);
      chk_bit("scaling", 1'b0, scal);
      for (int i = 0; i < 300 && !(wval === 1'b1 && rdy === 1'b1); i++) tick(1);
      tick(2);
      chk_bit("ready", 1'b1, rdy);
      chk_bit("word_valid", 1'b1, wval);
      chk_bit("scaling", 1'b1, scal);
      $display("rate test done");
      results();
   end
endmodule // adc_output_and_mode_control_tb

// file: tb/aoc_asserts.sv
// checker: pin relations between the converter end and the receiver end
`timescale 1ns/100ps
module aoc_asserts (
   input wire logic        clk_i,               // sample clock
   input wire logic        rst_n_i,             // reset, active low
   input wire logic [11:0] sample_i,            // raw code
   input wire logic        over_i,              // raw range flag
   input wire logic        ready_o,             // converter ready
   input wire logic [11:0] data_o,              // sample word
   input wire logic [11:0] data_oe_n,           // word enables
   input wire logic        range_exceeded_flag, // latched flag
   input wire logic [1:0]  power_state_select,  // power level
   input wire logic [1:0]  format_select,       // format level
   input wire logic        gray_select,         // gray request
   input wire logic        output_release       // bus release
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // coding is taken with the sample, so it must hold for the whole pipe
   sequence s_bin; (format_select < 2'h2 && !gray_select) [*8]; endsequence
   sequence s_twos; (format_select > 2'h1 && !gray_select) [*8]; endsequence
   sequence s_gray; gray_select [*8]; endsequence
   a_release_float: assert property (output_release [*2] |-> &data_oe_n)
      else $error("word driven while released");
   a_down_float: assert property ((power_state_select == 2'h3) [*2] |-> &data_oe_n)
      else $error("word driven in power-down");
   a_standby_float: assert property ((power_state_select == 2'h1) [*2] |-> &data_oe_n)
      else $error("word driven in standby");
   a_normal_drive: assert property ((power_state_select == 2'h0 && !output_release) [*2]
      |-> data_oe_n == 12'h000)
      else $error("word floating in normal state");
   a_flag_latency: assert property (range_exceeded_flag == $past(over_i, 8))
      else $error("flag latency wrong");
   a_binary_path: assert property (s_bin |=> data_o == $past(sample_i, 8))
      else $error("binary word wrong");
   a_twos_path: assert property (s_twos |=> data_o == ($past(sample_i, 8) ^ 12'h800))
      else $error("twos word wrong");
   a_gray_path: assert property (s_gray
      |=> data_o == ($past(sample_i, 8) ^ ($past(sample_i, 8) >> 1)))
      else $error("gray word wrong");
   a_down_unready: assert property ((power_state_select == 2'h3) [*2] |-> !ready_o)
      else $error("ready during power-down");
endmodule // aoc_asserts
